// File: rtl/prc_defines.svh
/*
  Register offsets, field positions, reset values and timing counts for the power
  and reset control block.
  Assumes a 32-bit APB slave, registers one aligned word each, pclk at 100 MHz.
*/
// Operation
// - Timer zero gate bit 5 freezes, resumes
// - Timer one gate bit 3 freezes, resumes
// - Serial peripheral gate bit 2 stops clock
// - USB gate bit 7 stops clock
// - Serial port gate bit 0 stops clock
// - Unassigned gate bits always read zero
// - Comparator off in sleep beyond idle
// - Comparator on reference keeps reference on
// - Reference enabled only when brownout/comparator need
// - Enabled brownout stays on in sleep
// - Enabled watchdog keeps running in sleep
// - Input buffers off when I/O clock stops
// - Debug fuse keeps main clock in sleep
// - Reset loads registers, restarts at vector
// - Ports reset asynchronously on power-on and pin; other sources via internal reset
// - Delay counter stretches reset after release
// - Internal reset combines exactly five sources
// - Power-on source follows supply detector
// - Long low pin pulse is external reset
// - Watchdog reset only when enabled, expired
// - Brownout reset only when enabled, low
// - USB reset keeps USB unit enabled
// - Gated peripheral frozen, registers inaccessible
// - Watchdog pulse one cycle, count from fall
// - Sources set flags; power-on/zero-write clear
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

`define PRC_ADDR_PR0        12'h000
`define PRC_ADDR_PR1        12'h004
`define PRC_ADDR_STATUS     12'h008
`define PRC_ADDR_SLEEP      12'h00c
`define PRC_ADDR_CONFIG     12'h010

`define PRC_PR0_MASK        8'h2c
`define PRC_PR1_MASK        8'h81
`define PRC_PR0_RESET       8'h00
`define PRC_PR1_RESET       8'h00

`define PRC_BIT_TIM0        5
`define PRC_BIT_TIM1        3
`define PRC_BIT_SPI         2
`define PRC_BIT_USB         7
`define PRC_BIT_USART       0

`define PRC_FLAG_POR        0
`define PRC_FLAG_EXT        1
`define PRC_FLAG_BOR        2
`define PRC_FLAG_WDR        3
`define PRC_FLAG_USB        5
`define PRC_STATUS_MASK     8'h2f

`define PRC_CFG_ACD         0
`define PRC_CFG_ACBG        1
`define PRC_CFG_WDE         2
`define PRC_CFG_USBRST_EN   3

`define PRC_BOD_DISABLED    3'h7
`define PRC_PIN_MIN_NS      400
`define PRC_CLK_NS          10
`define PRC_PIN_MIN_CYC     ((`PRC_PIN_MIN_NS + `PRC_CLK_NS - 1) / `PRC_CLK_NS)
`define PRC_SYNC_STAGES     2

`endif

// File: rtl/prc_pkg.sv
/*
  Types for the power and reset control block.
  Assumes prc_defines.svh supplies the numeric constants.
*/
package prc_pkg;
  typedef enum logic [2:0] {
    PRC_SLP_IDLE    = 3'b000,
    PRC_SLP_PDOWN   = 3'b010,
    PRC_SLP_PSAVE   = 3'b011,
    PRC_SLP_STANDBY = 3'b110,
    PRC_SLP_EXTSTBY = 3'b111
  } prc_sleep_t;

  typedef enum logic [1:0] {
    PRC_RST_ACTIVE  = 2'b00,
    PRC_RST_DELAY   = 2'b01,
    PRC_RST_RUN     = 2'b10
  } prc_rst_state_t;
endpackage

// File: rtl/prc_sync.sv
/*
  Two-flop level synchroniser for asynchronous reset-source inputs.
  Assumes input comes from outside the pclk domain; reset value is a parameter.
*/
`timescale 1ns/1ps
`default_nettype none
module prc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic din,      // Asynchronous level
  output logic      dout      // Synchronised level
);
  logic meta_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_reg <= RESET_VAL;
      dout     <= RESET_VAL;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule // prc_sync
`default_nettype wire

// File: rtl/prc_pulse_filter.sv
/*
  Qualifies an active-high level that must persist for MIN_CYC cycles.
  Assumes input already synchronised to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module prc_pulse_filter #(
  parameter int MIN_CYC = 40
) (
  input  wire logic pclk,     // System clock
  input  wire logic presetn,  // Async reset, active low
  input  wire logic din,      // Synchronised level
  output logic      qualified // High while level held long enough
);
  localparam int CW = $clog2(MIN_CYC + 1);
  logic [CW-1:0] cnt_reg;

  initial
  begin
    if (MIN_CYC < 1)
      $error("MIN_CYC must be at least 1");
  end

  assign qualified = (cnt_reg == CW'(MIN_CYC));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_reg <= '0;
    else if (!din)
      cnt_reg <= '0;
    else if (!qualified)
      cnt_reg <= cnt_reg + CW'(1);
  end
endmodule // prc_pulse_filter
`default_nettype wire

// File: rtl/prc_power_reset.sv
/*
  Power reduction, sleep power rules and reset combination with APB registers.
  Assumes analog detector outputs and the reset pin are asynchronous; the watchdog
  timeout and USB reset detect come from pclk logic. presetn is the APB reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.svh"
module prc_power_reset #(
  parameter int TIMEOUT_CYC = 16   // Default reset delay, used when timeout_cycles is zero
) (
  input  wire logic        pclk,           // System clock, 100 MHz
  input  wire logic        presetn,        // APB reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        supply_low,     // Supply below power-on threshold
  input  wire logic        reset_pin_n,    // External reset pin, active low
  input  wire logic        bod_below,      // Supply below brownout threshold
  input  wire logic [2:0]  brownout_level_select, // Brownout level fuses
  input  wire logic        wdt_expired,    // Watchdog period expired pulse
  input  wire logic        usb_bus_reset,  // USB bus reset detected
  input  wire logic        debug_enable_fuse, // On-chip debug fuse
  input  wire logic [15:0] timeout_cycles, // Delay from start-up/clock fuses
  input  wire logic        sleeping,       // Core in sleep
  input  wire logic        periph_req_tim0,// Register access to timer zero
  input  wire logic        periph_req_tim1,// Register access to timer one
  input  wire logic        periph_req_spi, // Register access to serial periph
  input  wire logic        periph_req_usb, // Register access to USB
  input  wire logic        periph_req_usart,// Register access to serial port
  output logic      [4:0]  periph_clk_en,  // Clock enables tim0,tim1,spi,usb,usart
  output logic      [4:0]  periph_acc_en,  // Register access allowed, same order
  output logic             comparator_en,  // Analog comparator power
  output logic             vref_en,        // Internal reference enable
  output logic             bod_en,         // Brownout detector enable
  output logic             wdt_run,        // Watchdog clock running
  output logic             input_buf_en,   // Digital input buffers enabled
  output logic             main_clk_en,    // Main clock source enabled
  output logic             port_reset_n,   // Async port reset, active low
  output logic             core_reset_n,   // Stretched internal reset, active low
  output logic             usb_reset_n,    // USB unit reset, active low
  output logic             fetch_restart   // Restart at reset vector pulse
);
  initial
  begin
    if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65535)
      $error("TIMEOUT_CYC out of range");
  end

  // APB decode
  wire        wr_en    = psel && penable && pwrite;
  wire        hit_pr0  = (paddr == `PRC_ADDR_PR0);
  wire        hit_pr1  = (paddr == `PRC_ADDR_PR1);
  wire        hit_st   = (paddr == `PRC_ADDR_STATUS);
  wire        hit_slp  = (paddr == `PRC_ADDR_SLEEP);
  wire        hit_cfg  = (paddr == `PRC_ADDR_CONFIG);
  wire        hit_any  = hit_pr0 | hit_pr1 | hit_st | hit_slp | hit_cfg;

  logic [7:0] pr0_reg;
  logic [7:0] pr1_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [2:0] sleep_mode_reg;
  logic [3:0] cfg_reg;

  // Reset sources, synchronised first so release is glitch-free
  logic por_sync;
  logic pin_sync;
  logic bod_sync;
  logic pin_held;

  prc_sync #(.RESET_VAL(1'b1)) u_sync_por (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (supply_low),
    .dout    (por_sync)
  );
  prc_sync #(.RESET_VAL(1'b0)) u_sync_pin (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (!reset_pin_n),
    .dout    (pin_sync)
  );
  prc_sync #(.RESET_VAL(1'b0)) u_sync_bod (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (bod_below),
    .dout    (bod_sync)
  );

  // Short glitches on the pin are not guaranteed to reset
  prc_pulse_filter #(.MIN_CYC(`PRC_PIN_MIN_CYC)) u_pin_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .din       (pin_sync),
    .qualified (pin_held)
  );

  wire bod_on   = (brownout_level_select != `PRC_BOD_DISABLED);
  wire src_por  = por_sync;
  wire src_ext  = pin_held;
  wire src_wdt  = wdt_expired && cfg_reg[`PRC_CFG_WDE];
  wire src_bod  = bod_on && bod_sync;
  wire src_usb  = usb_bus_reset && cfg_reg[`PRC_CFG_USBRST_EN];
  wire src_hard = src_por | src_ext | src_wdt | src_bod;     // All but USB bus reset
  wire any_src  = src_hard | src_usb;

  // Watchdog source is one cycle wide; count starts after it falls
  logic                     wdt_pulse_reg;
  prc_pkg::prc_rst_state_t  rst_state_reg;
  logic [15:0]              delay_cnt_reg;
  logic                     usb_only_reg;
  wire  [15:0]              delay_target = (timeout_cycles == 16'h0000)
                                           ? 16'(TIMEOUT_CYC) : timeout_cycles;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      wdt_pulse_reg <= 1'b0;
    else
      wdt_pulse_reg <= src_wdt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_state_reg <= prc_pkg::PRC_RST_ACTIVE;
      delay_cnt_reg <= 16'h0000;
      usb_only_reg  <= 1'b0;
    end
    else
    begin
      case (rst_state_reg)
        prc_pkg::PRC_RST_ACTIVE:
        begin
          delay_cnt_reg <= 16'h0000;
          // A harder source joining a USB-only reset must reset the USB unit too
          if (src_hard)
            usb_only_reg <= 1'b0;
          if (!any_src)
            rst_state_reg <= prc_pkg::PRC_RST_DELAY;
        end
        prc_pkg::PRC_RST_DELAY:
        begin
          if (any_src)
          begin
            delay_cnt_reg <= 16'h0000;
            usb_only_reg  <= usb_only_reg && !src_hard;
            rst_state_reg <= prc_pkg::PRC_RST_ACTIVE;
          end
          else if (delay_cnt_reg + 16'h0001 >= delay_target)
          begin
            rst_state_reg <= prc_pkg::PRC_RST_RUN;
            usb_only_reg  <= 1'b0;
          end
          else
            delay_cnt_reg <= delay_cnt_reg + 16'h0001;
        end
        prc_pkg::PRC_RST_RUN:
        begin
          if (any_src)
          begin
            rst_state_reg <= prc_pkg::PRC_RST_ACTIVE;
            usb_only_reg  <= src_usb && !src_hard;
          end
        end
        default:
          rst_state_reg <= prc_pkg::PRC_RST_ACTIVE;
      endcase
    end
  end

  wire in_reset = (rst_state_reg != prc_pkg::PRC_RST_RUN);
  assign core_reset_n  = !in_reset;
  assign port_reset_n  = presetn && !(supply_low || !reset_pin_n || in_reset);
  assign usb_reset_n   = !(in_reset && !usb_only_reg);
  assign fetch_restart = (rst_state_reg == prc_pkg::PRC_RST_DELAY) && !any_src
                         && (delay_cnt_reg + 16'h0001 >= delay_target);

  // Flags: set wins over software zero-write
  wire [7:0] wr_byte = pwdata[7:0];
  always_comb
  begin
    status_next = status_reg;
    if (wr_en && hit_st)
      status_next = status_next & wr_byte;
    if (src_por)
      status_next = status_next & 8'(1 << `PRC_FLAG_POR);
    status_next[`PRC_FLAG_POR] = status_next[`PRC_FLAG_POR] | src_por;
    status_next[`PRC_FLAG_EXT] = status_next[`PRC_FLAG_EXT] | src_ext;
    status_next[`PRC_FLAG_BOR] = status_next[`PRC_FLAG_BOR] | src_bod;
    status_next[`PRC_FLAG_WDR] = status_next[`PRC_FLAG_WDR] | src_wdt;
    status_next[`PRC_FLAG_USB] = status_next[`PRC_FLAG_USB] | src_usb;
    status_next = status_next & `PRC_STATUS_MASK;
  end

  // Registers reload while internal reset holds, except the status flags; a USB-only reset keeps cfg_reg and the PR1 USB bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pr0_reg        <= `PRC_PR0_RESET;
      pr1_reg        <= `PRC_PR1_RESET;
      sleep_mode_reg <= 3'h0;
      cfg_reg        <= 4'h0;
      status_reg     <= 8'h01;
    end
    else
    begin
      status_reg <= status_next;
      if (in_reset)
      begin
        pr0_reg        <= `PRC_PR0_RESET;
        pr1_reg        <= usb_only_reg ? (pr1_reg & 8'(1 << `PRC_BIT_USB)) : `PRC_PR1_RESET;
        sleep_mode_reg <= 3'h0;
        cfg_reg        <= usb_only_reg ? cfg_reg : 4'h0;
      end
      else if (wr_en)
      begin
        if (hit_pr0)
          pr0_reg <= wr_byte & `PRC_PR0_MASK;
        if (hit_pr1)
          pr1_reg <= wr_byte & `PRC_PR1_MASK;
        if (hit_slp)
          sleep_mode_reg <= wr_byte[2:0];
        if (hit_cfg)
          cfg_reg <= wr_byte[3:0];
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  wire [7:0] rd_byte = hit_pr0 ? pr0_reg :
                       hit_pr1 ? pr1_reg :
                       hit_st  ? status_reg :
                       hit_slp ? {5'h00, sleep_mode_reg} :
                       hit_cfg ? {4'h0, cfg_reg} : 8'h00;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {24'h00_0000, rd_byte};
  end

  // Peripheral gating: clock stops so state freezes and resumes
  wire [4:0] gate_vec = {pr0_reg[`PRC_BIT_TIM0], pr0_reg[`PRC_BIT_TIM1],
                         pr0_reg[`PRC_BIT_SPI], pr1_reg[`PRC_BIT_USB],
                         pr1_reg[`PRC_BIT_USART]};
  assign periph_clk_en = ~gate_vec;
  wire [4:0] req_vec = {periph_req_tim0, periph_req_tim1, periph_req_spi,
                        periph_req_usb, periph_req_usart};
  assign periph_acc_en = req_vec & ~gate_vec;

  // Sleep power rules
  wire deep_sleep = sleeping && (sleep_mode_reg != prc_pkg::PRC_SLP_IDLE);
  wire ac_cfg_on  = !cfg_reg[`PRC_CFG_ACD];
  wire ac_uses_bg = ac_cfg_on && cfg_reg[`PRC_CFG_ACBG];
  // Comparator still sleeps when it uses the reference; only the reference stays up
  assign comparator_en = ac_cfg_on && !deep_sleep;
  assign vref_en       = bod_en || ac_uses_bg;
  assign bod_en        = bod_on;
  assign wdt_run       = cfg_reg[`PRC_CFG_WDE];
  assign input_buf_en  = !deep_sleep;
  assign main_clk_en   = !sleeping || debug_enable_fuse ||
                         (sleep_mode_reg == prc_pkg::PRC_SLP_IDLE) ||
                         (sleep_mode_reg == prc_pkg::PRC_SLP_STANDBY) ||
                         (sleep_mode_reg == prc_pkg::PRC_SLP_EXTSTBY);

  // Checks
  AST_TIM0_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    pr0_reg[`PRC_BIT_TIM0] |-> !periph_clk_en[4])
    else $error("timer zero clock not gated");
  AST_TIM1_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !pr0_reg[`PRC_BIT_TIM1] |-> periph_clk_en[3])
    else $error("timer one clock not running");
  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    ((pr0_reg & ~`PRC_PR0_MASK) == 8'h00) && ((pr1_reg & ~`PRC_PR1_MASK) == 8'h00))
    else $error("reserved gate bit set");
  AST_AC_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    deep_sleep |-> !comparator_en)
    else $error("comparator on in deep sleep");
  AST_VREF: assert property (@(posedge pclk) disable iff (!presetn)
    vref_en == (bod_on || ac_uses_bg))
    else $error("reference enable wrong");
  AST_BUF: assert property (@(posedge pclk) disable iff (!presetn)
    deep_sleep |-> !input_buf_en)
    else $error("input buffers on in deep sleep");
  AST_SRC_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    any_src |=> !core_reset_n)
    else $error("source did not hold reset");
  AST_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_state_reg == prc_pkg::PRC_RST_ACTIVE && !any_src && delay_target >= 16'h0002)
      ##1 !any_src[*2]
      |-> !core_reset_n)
    else $error("reset released without delay");
  AST_RESTART: assert property (@(posedge pclk) disable iff (!presetn)
    (rst_state_reg == prc_pkg::PRC_RST_DELAY && any_src) |=> delay_cnt_reg == 16'h0000)
    else $error("delay not restarted");
  AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
    src_wdt |=> status_reg[`PRC_FLAG_WDR])
    else $error("watchdog flag not set");
  AST_USB_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (in_reset && usb_only_reg) |-> usb_reset_n)
    else $error("USB unit reset on bus reset");
  AST_WDT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
    (wdt_pulse_reg && !any_src) |=> (rst_state_reg == prc_pkg::PRC_RST_DELAY)
      && (delay_cnt_reg == 16'h0000))
    else $error("delay did not start after watchdog pulse");
  AST_PORT_ASYNC: assert property (@(posedge pclk) disable iff (!presetn)
    (supply_low || !reset_pin_n) |-> !port_reset_n)
    else $error("ports not held in reset");
  AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
    in_reset |=> (pr0_reg == `PRC_PR0_RESET))
    else $error("gate register not reloaded");
  AST_FETCH: assert property (@(posedge pclk) disable iff (!presetn)
    fetch_restart |=> core_reset_n)
    else $error("restart pulse not at release");
  AST_DEBUG_CLK: assert property (@(posedge pclk) disable iff (!presetn)
    debug_enable_fuse |-> main_clk_en)
    else $error("main clock stopped with debug fuse");
  AST_BOD_SLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    bod_on |-> (bod_en && vref_en))
    else $error("brownout detector off while selected");
  AST_WDT_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_reg[`PRC_CFG_WDE] |-> wdt_run)
    else $error("enabled watchdog stopped");
  AST_ACC_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    (periph_acc_en & ~periph_clk_en) == 5'h00)
    else $error("access to gated peripheral");
  AST_USB_HARD: assert property (@(posedge pclk) disable iff (!presetn)
    src_hard |=> !usb_reset_n)
    else $error("USB unit kept on a hard reset");

  COV_POR_RUN: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(core_reset_n));
  COV_RESTART: cover property (@(posedge pclk) disable iff (!presetn)
    rst_state_reg == prc_pkg::PRC_RST_DELAY && any_src);
  COV_USB_ONLY: cover property (@(posedge pclk) disable iff (!presetn)
    in_reset && usb_only_reg);
  COV_GATE: cover property (@(posedge pclk) disable iff (!presetn)
    periph_clk_en == 5'h00);
  COV_WDT: cover property (@(posedge pclk) disable iff (!presetn)
    wdt_pulse_reg && in_reset);
endmodule // prc_power_reset
`default_nettype wire

// File: bench/test_prc_power_reset.sv
/*
  Self-checking bench for the power and reset control block.
  Assumes prc_defines.svh and prc_pkg are compiled first; pclk runs at 100 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
`include "prc_defines.svh"
module test_prc_power_reset;
  localparam int TO = 4;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic        pready, pslverr, supply_low = 0, reset_pin_n = 1, bod_below = 0;
  logic [2:0]  lvl = 3'h7;
  logic        wdt_expired = 0, usb_bus_reset = 0, dbg = 0, sleeping = 0;
  logic [15:0] tmo = '0;
  logic [4:0]  req = '0, clk_en, acc_en;
  logic        cmp_en, vref_en, bod_en, wdt_run, ibuf_en, mclk_en;
  logic        port_rst_n, core_rst_n, usb_rst_n, fetch_rs;
  int          err_count = 0, compares = 0;
  // Register rows: address, write data, expected read-back
  logic [27:0] rrow [8] = '{28'h000ff2c, 28'h0002424, 28'h0000808, 28'h0000000,
                            28'h004ff81, 28'h0048080, 28'h0040101, 28'h0040000};
  // Reset-source rows: 0 supply, 1 pin, 2 brownout, 3 watchdog, 4 USB
  int          rs_src [8] = '{1, 1, 2, 2, 3, 3, 4, 0};
  int          rs_hold [8] = '{10, 60, 20, 20, 1, 1, 1, 5};
  logic [3:0]  rs_cfg [8] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h8, 4'h0};
  logic [2:0]  rs_lvl [8] = '{3'h7, 3'h7, 3'h7, 3'h6, 3'h7, 3'h7, 3'h7, 3'h7};
  logic [7:0]  rs_st [8] = '{8'h00, 8'h02, 8'h00, 8'h04, 8'h00, 8'h08, 8'h20, 8'h01};
  prc_pkg::prc_sleep_t md [5] = '{prc_pkg::PRC_SLP_IDLE, prc_pkg::PRC_SLP_PDOWN,
    prc_pkg::PRC_SLP_PSAVE, prc_pkg::PRC_SLP_STANDBY, prc_pkg::PRC_SLP_EXTSTBY};

  prc_power_reset #(.TIMEOUT_CYC(TO)) u_prc_power_reset (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .supply_low(supply_low),
    .reset_pin_n(reset_pin_n), .bod_below(bod_below), .brownout_level_select(lvl),
    .wdt_expired(wdt_expired), .usb_bus_reset(usb_bus_reset),
    .debug_enable_fuse(dbg), .timeout_cycles(tmo), .sleeping(sleeping),
    .periph_req_tim0(req[4]), .periph_req_tim1(req[3]), .periph_req_spi(req[2]),
    .periph_req_usb(req[1]), .periph_req_usart(req[0]), .periph_clk_en(clk_en),
    .periph_acc_en(acc_en), .comparator_en(cmp_en), .vref_en(vref_en),
    .bod_en(bod_en), .wdt_run(wdt_run), .input_buf_en(ibuf_en),
    .main_clk_en(mclk_en), .port_reset_n(port_rst_n), .core_reset_n(core_rst_n),
    .usb_reset_n(usb_rst_n), .fetch_restart(fetch_rs));

  always #5 pclk = ~pclk;

  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Called right after a rising edge; leaves one idle edge so signals are not reassigned
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int i;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      err_count++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic src_drive(input int s, input logic on);
    case (s)
      0: supply_low <= on;
      1: reset_pin_n <= !on;
      2: bod_below <= on;
      3: wdt_expired <= on;
      default: usb_bus_reset <= on;
    endcase
  endtask

  initial
  begin
    logic [31:0] rd;
    logic        er, seen, uok, ex, dp;
    logic [7:0]  p0, p1;
    logic [4:0]  ec;
    logic [2:0]  m;
    int          i, j, n, fr;
    p0 = '0;
    p1 = '0;
    repeat (20) @(posedge pclk);
    check("core_reset_n in reset", core_rst_n, 0);
    check("port_reset_n in reset", port_rst_n, 0);
    presetn <= 1;
    for (j = 0; j < 200 && core_rst_n !== 1'b1; j++)
      @(posedge pclk);
    check("release after reset", core_rst_n, 1);
    $display("test reset done");
    apb(0, `PRC_ADDR_PR0, 0, rd, er);
    check("pr0 reset", rd, 0);
    apb(0, `PRC_ADDR_PR1, 0, rd, er);
    check("pr1 reset", rd, 0);
    apb(0, `PRC_ADDR_STATUS, 0, rd, er);
    check("status reset", rd, 32'h1);
    for (i = 0; i < 8; i++)
    begin
      apb(1, rrow[i][27:16], {24'h0, rrow[i][15:8]}, rd, er);
      apb(0, rrow[i][27:16], 0, rd, er);
      check("gate readback", rd, {24'h0, rrow[i][7:0]});
      if (rrow[i][27:16] == `PRC_ADDR_PR0)
        p0 = rrow[i][7:0];
      else
        p1 = rrow[i][7:0];
      ec = ~{p0[5], p0[3], p0[2], p1[7], p1[0]};
      req <= 5'(i * 7);
      @(posedge pclk);
      check("periph_clk_en", clk_en, ec);
      check("periph_acc_en", acc_en, 5'(i * 7) & ec);
    end
    $display("test gates done");
    apb(0, 12'h020, 0, rd, er);
    check("unmapped pslverr", er, 1);
    check("unmapped read", rd, 0);
    apb(1, `PRC_ADDR_CONFIG, 32'h6, rd, er);
    for (i = 0; i < 10; i++)
    begin
      m = md[i / 2];
      apb(1, `PRC_ADDR_SLEEP, {29'h0, m}, rd, er);
      sleeping <= i[0];
      dbg <= m[0];
      @(posedge pclk);
      dp = i[0] && m != 3'b000;
      check("comparator_en", cmp_en, !dp);
      check("vref_en", vref_en, 1);
      check("wdt_run", wdt_run, 1);
      check("input_buf_en", ibuf_en, !dp);
      check("main_clk_en", mclk_en, !dp || m[0] || m[2]);
    end
    apb(1, `PRC_ADDR_CONFIG, 32'h1, rd, er);
    lvl <= 3'h6;
    @(posedge pclk);
    check("bod_en sleep", bod_en, 1);
    check("vref_en brownout", vref_en, 1);
    check("wdt_run off", wdt_run, 0);
    lvl <= 3'h7;
    sleeping <= 0;
    @(posedge pclk);
    check("vref_en none", vref_en, 0);
    $display("test sleep done");
    for (i = 0; i < 8; i++)
    begin
      ex = rs_st[i] != 0;
      apb(1, `PRC_ADDR_STATUS, 0, rd, er);
      apb(1, `PRC_ADDR_CONFIG, {28'h0, rs_cfg[i]}, rd, er);
      apb(1, `PRC_ADDR_PR0, 32'h2c, rd, er);
      lvl <= rs_lvl[i];
      src_drive(rs_src[i], 1);
      #1;
      if (ex && rs_src[i] < 2)
        check("port_reset_n async", port_rst_n, 0);
      repeat (rs_hold[i]) @(posedge pclk);
      src_drive(rs_src[i], 0);
      seen = 0;
      uok = 1;
      n = 0;
      fr = 0;
      for (j = 0; j < 150; j++)
      begin
        @(posedge pclk);
        uok = uok && usb_rst_n === 1'b1;
        fr += int'(fetch_rs === 1'b1);
        if (core_rst_n !== 1'b1)
        begin
          seen = 1;
          n++;
        end
        else if (seen)
          break;
      end
      if (j == 150 && (ex || seen))
      begin
        err_count++;
        report_and_stop();
      end
      check("reset seen", seen, ex);
      check("usb_reset_n held", uok, !(ex && rs_src[i] != 4));
      if (ex)
      begin
        check("delay length", n >= TO && n <= TO + 8, 1);
        check("fetch restart", fr, 1);
      end
      apb(0, `PRC_ADDR_STATUS, 0, rd, er);
      check("status flags", rd, {24'h0, rs_st[i]});
      apb(0, `PRC_ADDR_PR0, 0, rd, er);
      check("pr0 reload", rd, ex ? 32'h0 : 32'h2c);
    end
    $display("test sources done");
    // Reassertion inside a long delay must push the release out again
    tmo <= 16'd16;
    supply_low <= 1;
    repeat (5) @(posedge pclk);
    supply_low <= 0;
    repeat (6) @(posedge pclk);
    supply_low <= 1;
    repeat (3) @(posedge pclk);
    supply_low <= 0;
    for (n = 0; n < 100; n++)
    begin
      @(posedge pclk);
      if (core_rst_n === 1'b1)
        break;
    end
    check("delay restart", n >= 18 && n < 100, 1);
    $display("test restart done");
    report_and_stop();
  end
endmodule // test_prc_power_reset
`default_nettype wire
